// File: core/uart_fmt_pkg.sv
// constants for the frame-format and baud-divider block
// assumes a 32-bit AXI4-Lite slave with byte-wide registers in bits 7:0
package uart_fmt_pkg;
  localparam int ADDR_W = 8;
  localparam int DIV_W = 12;
  // register byte addresses
  localparam logic [7:0] OFF_FRAME = 8'h00;
  localparam logic [7:0] OFF_CTRL_B = 8'h04;
  localparam logic [7:0] OFF_DIV_LO = 8'h08;
  localparam logic [7:0] OFF_DIV_HI = 8'h0c;
  localparam logic [7:0] OFF_SPEED = 8'h10;
  localparam logic [7:0] OFF_STATUS = 8'h14;
  // frame_format_control fields
  localparam int FF_MODE_BIT = 6;
  localparam int FF_STOP_BIT = 3;
  localparam int FF_SIZE_LSB = 1;
  localparam int FF_POL_BIT = 0;
  localparam logic [7:0] FF_MASK = 8'h4f;
  // transceiver_control_b / speed fields
  localparam int CB_SIZE_HI_BIT = 2;
  localparam logic [7:0] CB_MASK = 8'h04;
  localparam int SP_DOUBLE_BIT = 1;
  localparam logic [7:0] SP_MASK = 8'h02;
  localparam logic [7:0] DIV_HI_MASK = 8'h0f;
  localparam logic [7:0] RESET_BYTE = 8'h00;
  // status fields
  localparam int ST_RSVD_BIT = 0;
  localparam int ST_BITS_LSB = 1;
  localparam int ST_STOP_LSB = 5;
  localparam int ST_SYNC_BIT = 7;
  // character size
  localparam logic [2:0] SIZE_NINE_CODE = 3'h7;
  localparam logic [3:0] SIZE_BASE_BITS = 4'h5;
  localparam logic [3:0] SIZE_NINE_BITS = 4'h9;
  localparam logic [3:0] SIZE_NONE = 4'h0;
  localparam logic [1:0] STOP_ONE = 2'h1;
  localparam logic [1:0] STOP_TWO = 2'h2;
  // oversampling: last index of 16 or 8 prescaler ticks per bit
  localparam logic [3:0] OVS_LAST_NORMAL = 4'hf;
  localparam logic [3:0] OVS_LAST_DOUBLE = 4'h7;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// File: core/baud_prescaler.sv
// baud prescaler: divider+1 clocks per oversample tick, 16 or 8 per bit
// assumes reload is a one-cycle pulse with divider already updated
`timescale 1ns/1ps
`default_nettype none
module baud_prescaler #(
  parameter int DIV_W = 12
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic clk_en,
  input wire logic reload,
  input wire logic [DIV_W-1:0] divider,
  input wire logic double_speed,
  output logic os_tick,
  output logic bit_tick
);
  logic [DIV_W-1:0] cnt, next_cnt;
  logic [3:0] ovs_cnt, next_ovs_cnt;
  logic next_os_tick, next_bit_tick;
  logic [3:0] ovs_last;

  always_comb begin
    ovs_last = double_speed ? uart_fmt_pkg::OVS_LAST_DOUBLE
                            : uart_fmt_pkg::OVS_LAST_NORMAL; // RULE11
    next_cnt = cnt;
    next_ovs_cnt = ovs_cnt;
    next_os_tick = 1'b0;
    next_bit_tick = 1'b0;
    if (reload) begin
      // restart at once, even mid-frame
      next_cnt = divider; // RULE7
      next_ovs_cnt = 4'h0; // RULE9
    end else if (cnt == '0) begin
      next_cnt = divider; // RULE13
      next_os_tick = 1'b1; // RULE10
      if (ovs_cnt >= ovs_last) begin
        next_ovs_cnt = 4'h0;
        next_bit_tick = 1'b1;
      end else begin
        next_ovs_cnt = ovs_cnt + 4'h1;
      end
    end else begin
      next_cnt = cnt - DIV_W'(1);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt <= '0;
      ovs_cnt <= 4'h0;
      os_tick <= 1'b0;
      bit_tick <= 1'b0;
    end else if (clk_en) begin
      cnt <= next_cnt;
      ovs_cnt <= next_ovs_cnt;
      os_tick <= next_os_tick;
      bit_tick <= next_bit_tick;
    end
  end

  AST_RELOAD: assert property (@(posedge aclk) disable iff (!aresetn)
    clk_en && reload |=> cnt == $past(divider)) // RULE7
    else $error("prescaler did not reload divider");
  AST_DIV_ZERO: assert property (@(posedge aclk) disable iff (!aresetn)
    clk_en && aresetn && !reload && cnt == '0 && divider == '0
    |=> os_tick) // RULE10
    else $error("zero divider missed a tick");
  AST_OVS: assert property (@(posedge aclk) disable iff (!aresetn)
    clk_en && !reload && cnt == '0 && ovs_cnt == ovs_last
    |=> bit_tick) // RULE11
    else $error("bit tick missing at oversample end");
  AST_BIT_ONLY_OS: assert property (@(posedge aclk) disable iff (!aresetn)
    bit_tick |-> os_tick) // RULE13
    else $error("bit tick without oversample tick");
  COV_BIT_DOUBLE: cover property (@(posedge aclk) disable iff (!aresetn)
    bit_tick && double_speed);
endmodule
`default_nettype wire

// File: core/uart_frame_cfg.sv
// frame-format and baud-divider registers with AXI4-Lite slave
// assumes a synchronous sync_serial_clock input and shift engines outside
// Overview of operation
// RULE1 - the transmitter uses one stop bit when the select is 0, two if 1.
// RULE2 - the receiver ignores the stop-bit select.
// RULE3 - codes 000-011 give 5-8 data bits, 111 gives 9, others reserved.
// RULE4 - polarity 0 shifts out on rising clock, samples on falling; 1 swaps.
// RULE5 - software keeps the polarity bit zero in asynchronous mode.
// RULE6 - the divider is 12 bits: high byte holds 11:8, low byte 7:0.
// RULE7 - writing the low byte reloads the prescaler with the full divider.
// RULE8 - software writes zero to high-byte bits 7:4, which read as zero.
// RULE9 - a divider change acts at once and corrupts frames in flight.
// RULE10 - divider zero gives the fastest asynchronous rate.
// RULE11 - double speed cuts oversampling from 16 to 8 in async mode only.
// RULE12 - mode select 0 is asynchronous, 1 synchronous on the serial clock.
// RULE13 - async rate is clock over 16 or 8 times divider plus one.
`timescale 1ns/1ps
`default_nettype none
module uart_frame_cfg #(
  parameter int ADDR_W = uart_fmt_pkg::ADDR_W,
  parameter int DIV_W = uart_fmt_pkg::DIV_W
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic clk_en,
  input wire logic [ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [ADDR_W-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic sync_serial_clock,
  output logic sync_mode,
  output logic [3:0] tx_data_bits,
  output logic [3:0] rx_data_bits,
  output logic [1:0] tx_stop_bits,
  output logic size_code_reserved,
  output logic tx_shift_strobe,
  output logic rx_sample_strobe
);
  ////////////////////////////////////////////////////////////////////////
  // register bus
  logic aw_got, next_aw_got, w_got, next_w_got;
  logic [ADDR_W-1:0] wr_addr, next_wr_addr;
  logic [7:0] wr_byte, next_wr_byte;
  logic wr_lane, next_wr_lane;
  logic next_awready, next_wready, next_bvalid, next_arready, next_rvalid;
  logic [1:0] next_bresp, next_rresp;
  logic [31:0] next_rdata;
  logic do_write;
  logic [7:0] frame_format_control, next_frame_format_control;
  logic [7:0] transceiver_control_b, next_transceiver_control_b;
  logic [7:0] speed_control, next_speed_control;
  logic [7:0] baud_divider_low_byte, next_baud_divider_low_byte;
  logic [7:0] baud_divider_high_byte, next_baud_divider_high_byte;
  logic reload, next_reload;
  logic [7:0] status_byte;

  assign do_write = aw_got && w_got && !bvalid;
  assign status_byte = {sync_mode, tx_stop_bits, rx_data_bits,
                        size_code_reserved};

  always_comb begin
    next_aw_got = aw_got;
    next_w_got = w_got;
    next_wr_addr = wr_addr;
    next_wr_byte = wr_byte;
    next_wr_lane = wr_lane;
    next_bvalid = bvalid;
    next_bresp = bresp;
    next_frame_format_control = frame_format_control;
    next_transceiver_control_b = transceiver_control_b;
    next_speed_control = speed_control;
    next_baud_divider_low_byte = baud_divider_low_byte;
    next_baud_divider_high_byte = baud_divider_high_byte;
    next_reload = 1'b0;
    if (awvalid && awready) begin
      next_aw_got = 1'b1;
      next_wr_addr = awaddr;
    end
    if (wvalid && wready) begin
      next_w_got = 1'b1;
      next_wr_byte = wdata[7:0];
      next_wr_lane = wstrb[0];
    end
    if (do_write) begin
      next_aw_got = 1'b0;
      next_w_got = 1'b0;
      next_bvalid = 1'b1;
      next_bresp = uart_fmt_pkg::RESP_OKAY;
      unique case (wr_addr)
        uart_fmt_pkg::OFF_FRAME: if (wr_lane) begin
          next_frame_format_control = wr_byte & uart_fmt_pkg::FF_MASK;
        end
        uart_fmt_pkg::OFF_CTRL_B: if (wr_lane) begin
          next_transceiver_control_b = wr_byte & uart_fmt_pkg::CB_MASK;
        end
        uart_fmt_pkg::OFF_SPEED: if (wr_lane) begin
          next_speed_control = wr_byte & uart_fmt_pkg::SP_MASK;
        end
        uart_fmt_pkg::OFF_DIV_LO: if (wr_lane) begin
          next_baud_divider_low_byte = wr_byte; // RULE6
          next_reload = 1'b1; // RULE7
        end
        uart_fmt_pkg::OFF_DIV_HI: if (wr_lane) begin
          // upper nibble kept at zero
          next_baud_divider_high_byte =
            wr_byte & uart_fmt_pkg::DIV_HI_MASK; // RULE8
        end
        uart_fmt_pkg::OFF_STATUS: begin
        end
        default: next_bresp = uart_fmt_pkg::RESP_SLVERR;
      endcase
    end
    if (bvalid && bready) begin
      next_bvalid = 1'b0;
    end
    next_awready = !next_aw_got && !next_bvalid;
    next_wready = !next_w_got && !next_bvalid;
  end

  always_comb begin
    next_rvalid = rvalid;
    next_rdata = rdata;
    next_rresp = rresp;
    if (arvalid && arready) begin
      next_rvalid = 1'b1;
      next_rresp = uart_fmt_pkg::RESP_OKAY;
      next_rdata = 32'h0000_0000;
      unique case (araddr)
        uart_fmt_pkg::OFF_FRAME: next_rdata[7:0] = frame_format_control;
        uart_fmt_pkg::OFF_CTRL_B: next_rdata[7:0] = transceiver_control_b;
        uart_fmt_pkg::OFF_SPEED: next_rdata[7:0] = speed_control;
        uart_fmt_pkg::OFF_DIV_LO: next_rdata[7:0] = baud_divider_low_byte;
        uart_fmt_pkg::OFF_DIV_HI: next_rdata[7:0] = baud_divider_high_byte;
        uart_fmt_pkg::OFF_STATUS: next_rdata[7:0] = status_byte;
        default: next_rresp = uart_fmt_pkg::RESP_SLVERR;
      endcase
    end else if (rvalid && rready) begin
      next_rvalid = 1'b0;
    end
    next_arready = !next_rvalid;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got <= 1'b0;
      w_got <= 1'b0;
      wr_addr <= '0;
      wr_byte <= uart_fmt_pkg::RESET_BYTE;
      wr_lane <= 1'b0;
      awready <= 1'b0;
      wready <= 1'b0;
      bvalid <= 1'b0;
      bresp <= uart_fmt_pkg::RESP_OKAY;
      arready <= 1'b0;
      rvalid <= 1'b0;
      rdata <= 32'h0000_0000;
      rresp <= uart_fmt_pkg::RESP_OKAY;
      frame_format_control <= uart_fmt_pkg::RESET_BYTE;
      transceiver_control_b <= uart_fmt_pkg::RESET_BYTE;
      speed_control <= uart_fmt_pkg::RESET_BYTE;
      baud_divider_low_byte <= uart_fmt_pkg::RESET_BYTE;
      baud_divider_high_byte <= uart_fmt_pkg::RESET_BYTE;
      reload <= 1'b0;
    end else if (clk_en) begin
      aw_got <= next_aw_got;
      w_got <= next_w_got;
      wr_addr <= next_wr_addr;
      wr_byte <= next_wr_byte;
      wr_lane <= next_wr_lane;
      awready <= next_awready;
      wready <= next_wready;
      bvalid <= next_bvalid;
      bresp <= next_bresp;
      arready <= next_arready;
      rvalid <= next_rvalid;
      rdata <= next_rdata;
      rresp <= next_rresp;
      frame_format_control <= next_frame_format_control;
      transceiver_control_b <= next_transceiver_control_b;
      speed_control <= next_speed_control;
      baud_divider_low_byte <= next_baud_divider_low_byte;
      baud_divider_high_byte <= next_baud_divider_high_byte;
      reload <= next_reload;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // prescaler
  logic [DIV_W-1:0] baud_divider;
  logic double_speed, os_tick, bit_tick;

  assign baud_divider = {baud_divider_high_byte[3:0],
                         baud_divider_low_byte}; // RULE6
  assign double_speed = speed_control[uart_fmt_pkg::SP_DOUBLE_BIT];

  baud_prescaler #(.DIV_W(DIV_W)) u_prescaler (
    .aclk(aclk),
    .aresetn(aresetn),
    .clk_en(clk_en),
    .reload(reload),
    .divider(baud_divider),
    .double_speed(double_speed),
    .os_tick(os_tick),
    .bit_tick(bit_tick)
  );

  ////////////////////////////////////////////////////////////////////////
  // frame format and strobes
  logic [2:0] size_code;
  logic stop_sel, pol, mode_sel, sck_q, sck_rise, sck_fall;
  logic next_sync_mode, next_size_code_reserved, next_sck_q;
  logic next_tx_shift_strobe, next_rx_sample_strobe;
  logic [3:0] next_data_bits;
  logic [1:0] next_tx_stop_bits;

  assign size_code = {
    transceiver_control_b[uart_fmt_pkg::CB_SIZE_HI_BIT],
    frame_format_control[uart_fmt_pkg::FF_SIZE_LSB+:2]};
  assign stop_sel = frame_format_control[uart_fmt_pkg::FF_STOP_BIT];
  assign pol = frame_format_control[uart_fmt_pkg::FF_POL_BIT];
  assign mode_sel = frame_format_control[uart_fmt_pkg::FF_MODE_BIT];
  assign sck_rise = sync_serial_clock && !sck_q;
  assign sck_fall = !sync_serial_clock && sck_q;

  always_comb begin
    next_sck_q = sync_serial_clock;
    next_sync_mode = mode_sel; // RULE12
    next_tx_stop_bits = stop_sel ? uart_fmt_pkg::STOP_TWO
                                 : uart_fmt_pkg::STOP_ONE; // RULE1
    next_size_code_reserved = 1'b0;
    unique case (size_code)
      3'h0, 3'h1, 3'h2, 3'h3:
        next_data_bits = uart_fmt_pkg::SIZE_BASE_BITS +
                         {2'h0, size_code[1:0]}; // RULE3
      uart_fmt_pkg::SIZE_NINE_CODE:
        next_data_bits = uart_fmt_pkg::SIZE_NINE_BITS; // RULE3
      default: begin
        next_data_bits = uart_fmt_pkg::SIZE_NONE;
        next_size_code_reserved = 1'b1;
      end
    endcase
    if (mode_sel) begin
      // serial clock edges; double speed has no say here
      next_tx_shift_strobe = pol ? sck_fall : sck_rise; // RULE4
      next_rx_sample_strobe = pol ? sck_rise : sck_fall; // RULE4
    end else begin
      next_tx_shift_strobe = bit_tick; // RULE13
      next_rx_sample_strobe = os_tick; // RULE12
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sck_q <= 1'b0;
      sync_mode <= 1'b0;
      tx_data_bits <= uart_fmt_pkg::SIZE_NONE;
      rx_data_bits <= uart_fmt_pkg::SIZE_NONE;
      tx_stop_bits <= uart_fmt_pkg::STOP_ONE;
      size_code_reserved <= 1'b0;
      tx_shift_strobe <= 1'b0;
      rx_sample_strobe <= 1'b0;
    end else if (clk_en) begin
      sck_q <= next_sck_q;
      sync_mode <= next_sync_mode;
      tx_data_bits <= next_data_bits;
      rx_data_bits <= next_data_bits; // RULE2
      tx_stop_bits <= next_tx_stop_bits;
      size_code_reserved <= next_size_code_reserved;
      tx_shift_strobe <= next_tx_shift_strobe;
      rx_sample_strobe <= next_rx_sample_strobe;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // checks
  AST_STOP: assert property (@(posedge aclk) disable iff (!aresetn)
    clk_en |=> tx_stop_bits == ($past(stop_sel) ? 2'h2 : 2'h1)) // RULE1
    else $error("stop bit count wrong");
  AST_RX_NO_STOP: assert property (@(posedge aclk) disable iff (!aresetn)
    clk_en |=> rx_data_bits == tx_data_bits) // RULE2
    else $error("receiver size differs from transmitter");
  AST_SIZE: assert property (@(posedge aclk) disable iff (!aresetn) // RULE3
    clk_en && aresetn |=> tx_data_bits == ($past(size_code) == 3'h7 ? 4'h9 :
      $past(size_code) < 3'h4 ? 4'h5 + {1'b0, $past(size_code)} : 4'h0))
    else $error("character size decode wrong");
  AST_POL: assert property (@(posedge aclk) disable iff (!aresetn)
    clk_en && mode_sel && sck_rise |=> (tx_shift_strobe == !$past(pol))
      && (rx_sample_strobe == $past(pol))) // RULE4
    else $error("sync edge polarity wrong");
  AST_DIV_HI_ZERO: assert property (@(posedge aclk) disable iff (!aresetn)
    baud_divider_high_byte[7:4] == 4'h0) // RULE8
    else $error("divider high nibble not zero");
  AST_LO_RELOAD: assert property (@(posedge aclk) disable iff (!aresetn)
    clk_en && do_write && wr_addr == uart_fmt_pkg::OFF_DIV_LO && wr_lane
    |=> reload && baud_divider[7:0] == $past(wr_byte)) // RULE9
    else $error("low byte write did not reload");
  AST_ASYNC_SRC: assert property (@(posedge aclk) disable iff (!aresetn)
    clk_en && !mode_sel |=> rx_sample_strobe == $past(os_tick)
      && tx_shift_strobe == $past(bit_tick)) // RULE12
    else $error("async strobes not from prescaler");
  AST_WRITE_RESP: assert property (@(posedge aclk) disable iff (!aresetn)
    clk_en && awvalid && awready && wvalid && wready
    ##1 clk_en |=> bvalid) // AXI write response
    else $error("write response late");
  COV_LO_WRITE: cover property (@(posedge aclk) disable iff (!aresetn)
    reload);
  COV_SYNC_SAMPLE: cover property (@(posedge aclk) disable iff (!aresetn)
    sync_mode && rx_sample_strobe);
  COV_NINE: cover property (@(posedge aclk) disable iff (!aresetn)
    tx_data_bits == 4'h9);
  COV_RSVD: cover property (@(posedge aclk) disable iff (!aresetn)
    size_code_reserved);
endmodule
`default_nettype wire

// File: dv/remote_serial_dev.sv
// remote serial device model: makes the synchronous serial clock
// assumes the bench pulses toggle_req for one aclk cycle per wanted edge
`timescale 1ns/1ps
`default_nettype none
module remote_serial_dev (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic toggle_req,
  output logic sync_serial_clock
);
  logic next_level;
  // clock stands still between commanded edges, idle low
  always_comb begin
    next_level = sync_serial_clock;
    if (toggle_req) begin
      next_level = ~sync_serial_clock;
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sync_serial_clock <= 1'b0;
    end else begin
      sync_serial_clock <= next_level;
    end
  end
endmodule
`default_nettype wire

// File: dv/tb.sv
// testbench for the frame-format and baud-divider block
// assumes AXI4-Lite access and the remote serial device model
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic aclk = 1'b0, aresetn = 1'b0, clk_en = 1'b1, toggle_req = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata;
  logic [3:0] wstrb = 4'h0, tx_data_bits, rx_data_bits;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, sync_serial_clock;
  logic sync_mode, size_code_reserved, tx_shift_strobe, rx_sample_strobe;
  logic [1:0] bresp, rresp, tx_stop_bits, resp;
  logic [31:0] rd;
  logic [3:0] exp_bits [8];
  int bad_count = 0, n_compared = 0, len;
  always #20 aclk = ~aclk;
  uart_frame_cfg uut (.aclk(aclk), .aresetn(aresetn), .clk_en(clk_en),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .sync_serial_clock(sync_serial_clock), .sync_mode(sync_mode),
    .tx_data_bits(tx_data_bits), .rx_data_bits(rx_data_bits),
    .tx_stop_bits(tx_stop_bits), .size_code_reserved(size_code_reserved),
    .tx_shift_strobe(tx_shift_strobe), .rx_sample_strobe(rx_sample_strobe));
  remote_serial_dev peer (.aclk(aclk), .aresetn(aresetn),
    .toggle_req(toggle_req), .sync_serial_clock(sync_serial_clock));
  ////////////////////////////////////////////////////////////////////////
  task automatic check(input string name, input logic [31:0] exp,
      input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic axi_write(input logic [7:0] a, input logic [31:0] d,
      output logic [1:0] r);
    int n;
    n = 0;
    r = 2'h3;
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'h1;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (n < 100) begin
      @(posedge aclk);
      n++;
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid === 1'b1) begin
        r = bresp;
        bready <= 1'b0;
        break;
      end
    end
    if (n >= 100) check("write timeout", 32'h0, 32'h1);
    @(posedge aclk);
  endtask
  task automatic axi_read(input logic [7:0] a, output logic [31:0] d,
      output logic [1:0] r);
    int n;
    n = 0;
    r = 2'h3;
    d = 32'h0;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (n < 100) begin
      @(posedge aclk);
      n++;
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid === 1'b1) begin
        d = rdata;
        r = rresp;
        rready <= 1'b0;
        break;
      end
    end
    if (n >= 100) check("read timeout", 32'h0, 32'h1);
    @(posedge aclk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    axi_write(a, d, resp);
    check("bresp", {30'h0, uart_fmt_pkg::RESP_OKAY}, {30'h0, resp});
    repeat (3) @(posedge aclk);
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    axi_read(a, rd, resp);
    check("rresp", {30'h0, uart_fmt_pkg::RESP_OKAY}, {30'h0, resp});
    check("rdata", exp, rd);
  endtask
  // cycles between two successive strobes of the chosen kind
  task automatic measure(input logic use_tx, output int p);
    int n;
    n = 0;
    for (int k = 0; k < 2; k++) begin
      @(posedge aclk);
      n = 1;
      while ((use_tx ? tx_shift_strobe : rx_sample_strobe) !== 1'b1
          && n < 2000) begin
        @(posedge aclk);
        n++;
      end
    end
    p = n;
  endtask
  task automatic sync_edge(input logic exp_tx);
    int ntx, nrx;
    ntx = 0;
    nrx = 0;
    toggle_req <= 1'b1;
    @(posedge aclk);
    toggle_req <= 1'b0;
    repeat (5) begin
      @(posedge aclk);
      if (tx_shift_strobe === 1'b1) ntx++;
      if (rx_sample_strobe === 1'b1) nrx++;
    end
    check("sync tx strobes", {31'h0, exp_tx}, ntx);
    check("sync rx strobes", {31'h0, ~exp_tx}, nrx);
  endtask
  task automatic complete_run;
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20000) @(posedge aclk);
    bad_count++;
    complete_run();
  end
  initial begin
    exp_bits = '{4'h5, 4'h6, 4'h7, 4'h8, 4'h0, 4'h0, 4'h0, 4'h9};
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    check("reset bits", 32'h5, {28'h0, tx_data_bits});
    check("reset stop", 32'h1, {30'h0, tx_stop_bits});
    rd_chk(uart_fmt_pkg::OFF_DIV_LO, 32'h0);
    rd_chk(uart_fmt_pkg::OFF_DIV_HI, 32'h0);
    rd_chk(uart_fmt_pkg::OFF_STATUS, 32'h2a);
    wr(uart_fmt_pkg::OFF_STATUS, 32'hff);
    rd_chk(uart_fmt_pkg::OFF_STATUS, 32'h2a);
    axi_read(8'h20, rd, resp);
    check("unmapped rresp", 32'h2, {30'h0, resp});
    axi_write(8'h20, 32'h5a, resp);
    check("unmapped bresp", 32'h2, {30'h0, resp});
    $display("test registers done");
    wr(uart_fmt_pkg::OFF_FRAME, 32'h08);
    check("two stop", 32'h2, {30'h0, tx_stop_bits});
    check("rx bits", 32'h5, {28'h0, rx_data_bits});
    wr(uart_fmt_pkg::OFF_FRAME, 32'h00);
    check("one stop", 32'h1, {30'h0, tx_stop_bits});
    for (int i = 0; i < 8; i++) begin
      wr(uart_fmt_pkg::OFF_CTRL_B, {29'h0, i[2], 2'h0});
      wr(uart_fmt_pkg::OFF_FRAME, {29'h0, i[1:0], 1'b0});
      check("tx bits", {28'h0, exp_bits[i]}, {28'h0, tx_data_bits});
      check("rx bits", {28'h0, exp_bits[i]}, {28'h0, rx_data_bits});
      check("reserved", {31'h0, i >= 4 && i <= 6},
        {31'h0, size_code_reserved});
    end
    $display("test frame format done");
    wr(uart_fmt_pkg::OFF_DIV_HI, 32'hff);
    rd_chk(uart_fmt_pkg::OFF_DIV_HI, 32'h0f);
    wr(uart_fmt_pkg::OFF_DIV_HI, 32'h00);
    wr(uart_fmt_pkg::OFF_DIV_LO, 32'h02);
    rd_chk(uart_fmt_pkg::OFF_DIV_LO, 32'h02);
    measure(1'b1, len);
    check("bit period", 32'd48, len);
    measure(1'b0, len);
    check("sample period", 32'd3, len);
    wr(uart_fmt_pkg::OFF_SPEED, 32'h02);
    measure(1'b1, len);
    check("double period", 32'd24, len);
    wr(uart_fmt_pkg::OFF_DIV_LO, 32'h00);
    measure(1'b1, len);
    check("fast double", 32'd8, len);
    wr(uart_fmt_pkg::OFF_SPEED, 32'h00);
    measure(1'b1, len);
    check("fast normal", 32'd16, len);
    $display("test baud done");
    wr(uart_fmt_pkg::OFF_FRAME, 32'h46);
    check("sync mode", 32'h1, {31'h0, sync_mode});
    repeat (4) @(posedge aclk);
    sync_edge(1'b1);
    sync_edge(1'b0);
    wr(uart_fmt_pkg::OFF_FRAME, 32'h47);
    sync_edge(1'b0);
    sync_edge(1'b1);
    wr(uart_fmt_pkg::OFF_FRAME, 32'h00);
    check("async mode", 32'h0, {31'h0, sync_mode});
    $display("test sync done");
    complete_run();
  end
endmodule
`default_nettype wire
